/* hdl/crf_fifo.sv */
// One receive FIFO: message store, pointers and pending count.
// Assumes push and pop are single-cycle pulses in the ref_clk domain.
`timescale 1ns/10ps
module crf_fifo (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic push,
   input wire logic [crf_pkg::MSG_W-1:0] push_data,
   input wire logic pop,
   output logic [crf_pkg::CNT_W-1:0] count_q,
   output logic [crf_pkg::MSG_W-1:0] head_data,
   output logic overrun
);
   import crf_pkg::*;
   logic [MSG_W-1:0] mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic do_pop;
   logic do_push;
   logic [1:0] full_lvl;
   logic [1:0] last_ptr;

   assign full_lvl = 2'(FIFO_DEPTH);
   assign last_ptr = 2'(FIFO_DEPTH - 1);
   assign do_pop = pop && (count_q != '0);
   // A push into a full FIFO is dropped unless a release frees a slot in the same cycle.
   assign do_push = push && ((count_q != full_lvl) || do_pop);
   assign overrun = push && !do_push;
   assign head_data = mem[rd_ptr_q];

   // Both pointers advance independently so a coincident release and store stay consistent.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_q <= (wr_ptr_q == last_ptr) ? '0 : wr_ptr_q + 2'd1;
         end
         if (do_pop) begin
            rd_ptr_q <= (rd_ptr_q == last_ptr) ? '0 : rd_ptr_q + 2'd1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (do_push) begin
         mem[wr_ptr_q] <= push_data;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_q <= '0;
      end else if (do_push && !do_pop) begin
         count_q <= count_q + 2'd1;
      end else if (do_pop && !do_push) begin
         count_q <= count_q - 2'd1;
      end
      // Simultaneous push and pop leaves the count unchanged.
   end
endmodule // crf_fifo

/* hdl/crf_pkg.sv */
// Constants for the CAN receive FIFO bookkeeping block.
// Assumes a single 125 MHz clock and an AXI4-Lite register bus.
package crf_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 3;
   localparam int PTR_W = 2;
   localparam int CNT_W = 2;
   localparam int MSG_W = 32;
   localparam int NUM_FIFO = 2;
   // Register byte addresses.
   localparam logic [ADDR_W-1:0] ADDR_FIFO0_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_FIFO1_CTRL = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_CELL_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_DIAGNOSIS = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_FIFO0_DATA = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_FIFO1_DATA = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h1c;
   localparam logic [ADDR_W-1:0] ADDR_BIT_TIMING = 8'h20;
   // Field positions.
   localparam int CTRL_COUNT_LSB = 0;
   localparam int CTRL_RELEASE_BIT = 5;
   localparam int STATUS_RX_BUSY_BIT = 5;
   localparam int DIAG_RX_PIN_BIT = 3;
   localparam int TIM_SEG1_LSB = 8;
   localparam int TIM_SEG2_LSB = 12;
   localparam int TIM_SEG_W = 4;
   localparam int TIM_PRESC_W = 6;
   localparam int IRQ_W = 4;
   // Bit timing: 8 to 25 quanta per bit, sync quantum plus segments; register writes are not limited to this range.
   localparam int QUANTA_MIN = 8;
   localparam int QUANTA_MAX = 25;
   localparam logic [TIM_SEG_W-1:0] SEG1_RESET = 4'h3;
   localparam logic [TIM_SEG_W-1:0] SEG2_RESET = 4'h2;
   localparam logic [TIM_PRESC_W-1:0] PRESC_RESET = 6'h00;
   // Bits from acknowledge to the store slot: delimiter plus end of frame.
   localparam int ACK_TO_STORE_BITS = 6;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* hdl/crf_top.sv */
// CAN receive FIFO bookkeeping: two receive FIFOs, status and diagnosis.
// Assumes AXI4-Lite on ref_clk; the frame engine supplies acknowledge and message pulses.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps

// Summary of operation
// - Low two bits of each FIFO control register show pending messages.
// - Cell status bit 5 reads one while a frame is being received.
// - Writing release bit frees oldest message, count drops by one.
// - A received message is stored by a one-cycle transfer pulse.
// - Coincident release and store keep the count correct.
// - Store happens at frame end, six bits plus sample point after acknowledge.
// - Diagnosis bit 3 shows live receive pin; zero means dominant.
// - Bit timing rule is 8 to 25 quanta, minimum prescaler 0, segments 5; the register takes any fields, 3 to 33 quanta.
// - At 8 MHz and 1 Mbit/s, 56 cycles precede the store window.
// - Two independent receive FIFOs, each with own control and release.
module crf_top (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [crf_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [crf_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [crf_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [crf_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic can_rx_pin,
   input wire logic rx_frame_active,
   input wire logic rx_ack_seen,
   input wire logic rx_msg_valid,
   input wire logic rx_msg_fifo,
   input wire logic [crf_pkg::MSG_W-1:0] rx_msg_data,
   output logic rx_store_q,
   output logic [crf_pkg::TIM_PRESC_W-1:0] baud_prescaler_q,
   output logic [crf_pkg::TIM_SEG_W-1:0] time_segment_one_q,
   output logic [crf_pkg::TIM_SEG_W-1:0] time_segment_two_q,
   output logic irq_q
);
   import crf_pkg::*;

   // ---------------------------------------------------------------
   // Receive side: message hold and end-of-frame store
   // ---------------------------------------------------------------
   logic receive_in_progress_q;
   logic rx_pin_q;
   logic [MSG_W-1:0] msg_hold_q;
   logic msg_fifo_q;
   logic msg_ready_q;
   logic ack_armed_q;
   logic [7:0] ack_bits_q;
   logic [7:0] quanta_q;
   logic [TIM_PRESC_W-1:0] presc_cnt_q;
   logic [7:0] bit_quanta;
   logic bit_tick;
   logic store_now;
   logic [NUM_FIFO-1:0] push_vec;
   logic [NUM_FIFO-1:0] pop_vec;
   logic [NUM_FIFO-1:0] ovr_vec;
   logic [CNT_W-1:0] cnt [NUM_FIFO];
   logic [MSG_W-1:0] head [NUM_FIFO];

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         receive_in_progress_q <= 1'b0;
         rx_pin_q <= 1'b1;
      end else begin
         receive_in_progress_q <= rx_frame_active;
         rx_pin_q <= can_rx_pin;
      end
   end

   // Bit length in quanta: one sync quantum plus both segments, each field plus one.
   assign bit_quanta = 8'd3 + 8'(time_segment_one_q) + 8'(time_segment_two_q);
   assign bit_tick = (presc_cnt_q == baud_prescaler_q) && (quanta_q == bit_quanta - 8'd1);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         presc_cnt_q <= '0;
         quanta_q <= '0;
      end else if (!ack_armed_q || rx_ack_seen) begin
         presc_cnt_q <= '0;
         quanta_q <= '0;
      end else if (presc_cnt_q != baud_prescaler_q) begin
         presc_cnt_q <= presc_cnt_q + 6'd1;
      end else begin
         presc_cnt_q <= '0;
         quanta_q <= bit_tick ? '0 : quanta_q + 8'd1;
      end
   end

   // Counted from the acknowledge sample point: the rest of that bit, six recessive bits and
   // the part of the next bit up to its sample point add up to one bit more than six.
   localparam logic [7:0] STORE_BITS = 8'(ACK_TO_STORE_BITS + 1);
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         msg_ready_q <= 1'b0;
         msg_hold_q <= '0;
         msg_fifo_q <= 1'b0;
         ack_armed_q <= 1'b0;
         ack_bits_q <= '0;
      end else begin
         if (rx_msg_valid) begin
            msg_ready_q <= 1'b1;
            msg_hold_q <= rx_msg_data;
            msg_fifo_q <= rx_msg_fifo;
         end else if (store_now) begin
            msg_ready_q <= 1'b0;
         end
         if (rx_ack_seen) begin
            ack_armed_q <= 1'b1;
            ack_bits_q <= '0;
         end else if (store_now) begin
            ack_armed_q <= 1'b0;
         end else if (bit_tick && ack_bits_q != STORE_BITS) begin
            ack_bits_q <= ack_bits_q + 8'd1;
         end
      end
   end

   assign store_now = msg_ready_q && ack_armed_q && (ack_bits_q == STORE_BITS)
      && !rx_msg_valid;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_store_q <= 1'b0;
      end else begin
         rx_store_q <= store_now;
      end
   end

   // ---------------------------------------------------------------
   // Receive FIFOs
   // ---------------------------------------------------------------
   logic wr_fire;
   logic [ADDR_W-1:0] aw_q;
   logic [DATA_W-1:0] w_q;
   logic [3:0] ws_q;
   logic aw_have_q;
   logic w_have_q;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_FIFO; gi++) begin : g_fifo
         localparam logic [ADDR_W-1:0] CTRL_ADDR = gi == 0 ? ADDR_FIFO0_CTRL : ADDR_FIFO1_CTRL;
         assign push_vec[gi] = store_now && (msg_fifo_q == 1'(gi));
         assign pop_vec[gi] = wr_fire && (aw_q == CTRL_ADDR) && ws_q[0]
            && w_q[CTRL_RELEASE_BIT];
         crf_fifo crf_fifo_i (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .push(push_vec[gi]),
            .push_data(msg_hold_q),
            .pop(pop_vec[gi]),
            .count_q(cnt[gi]),
            .head_data(head[gi]),
            .overrun(ovr_vec[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Interrupts: stored, overrun per FIFO
   // ---------------------------------------------------------------
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_set;
   logic irq_clr_wr;

   assign irq_set = {ovr_vec, push_vec};
   assign irq_clr_wr = wr_fire && (aw_q == ADDR_IRQ_STATUS) && ws_q[0];

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_stat_q <= '0;
      end else if (irq_clr_wr) begin
         irq_stat_q <= (irq_stat_q & ~w_q[IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= '0;
         w_q <= '0;
         ws_q <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_q <= ADDR_BIT_TIMING && aw_q[1:0] == 2'b00) ? RESP_OKAY
               : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_mask_q <= '0;
         baud_prescaler_q <= PRESC_RESET;
         time_segment_one_q <= SEG1_RESET;
         time_segment_two_q <= SEG2_RESET;
      end else if (wr_fire) begin
         if (aw_q == ADDR_IRQ_MASK && ws_q[0]) begin
            irq_mask_q <= w_q[IRQ_W-1:0];
         end
         if (aw_q == ADDR_BIT_TIMING) begin
            if (ws_q[0]) begin
               baud_prescaler_q <= w_q[TIM_PRESC_W-1:0];
            end
            if (ws_q[1]) begin
               time_segment_one_q <= w_q[TIM_SEG1_LSB +: TIM_SEG_W];
               time_segment_two_q <= w_q[TIM_SEG2_LSB +: TIM_SEG_W];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] rd_word;
   logic rd_ok;

   always_comb begin
      rd_word = '0;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         ADDR_FIFO0_CTRL: rd_word[CTRL_COUNT_LSB +: CNT_W] = cnt[0];
         ADDR_FIFO1_CTRL: rd_word[CTRL_COUNT_LSB +: CNT_W] = cnt[1];
         ADDR_CELL_STATUS: rd_word[STATUS_RX_BUSY_BIT] = receive_in_progress_q;
         ADDR_DIAGNOSIS: rd_word[DIAG_RX_PIN_BIT] = rx_pin_q;
         ADDR_FIFO0_DATA: rd_word = head[0];
         ADDR_FIFO1_DATA: rd_word = head[1];
         ADDR_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_stat_q;
         ADDR_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_q;
         ADDR_BIT_TIMING: begin
            rd_word[TIM_PRESC_W-1:0] = baud_prescaler_q;
            rd_word[TIM_SEG1_LSB +: TIM_SEG_W] = time_segment_one_q;
            rd_word[TIM_SEG2_LSB +: TIM_SEG_W] = time_segment_two_q;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // crf_top

/* tb/can_rx_fifo_release_test.sv */
// Self-checking bench for crf_top with the bus-side stand-in.
// Assumes crf_top, crf_can_node and the bound checker are compiled first.
`timescale 1ns/10ps
module can_rx_fifo_release_test;
   import crf_pkg::*;
   logic ref_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic can_rx_pin, rx_frame_active, rx_ack_seen, rx_msg_valid, rx_msg_fifo, rx_store_q, irq_q;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [MSG_W-1:0] rx_msg_data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [TIM_PRESC_W-1:0] baud_prescaler_q;
   logic [TIM_SEG_W-1:0] time_segment_one_q, time_segment_two_q;
   int n_fail = 0;
   int num_checks = 0;
   crf_top crf_top_i (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .can_rx_pin, .rx_frame_active, .rx_ack_seen, .rx_msg_valid,
      .rx_msg_fifo, .rx_msg_data, .rx_store_q, .baud_prescaler_q, .time_segment_one_q,
      .time_segment_two_q, .irq_q);
   crf_can_node crf_can_node_i (.ref_clk, .can_rx_pin, .rx_frame_active, .rx_ack_seen,
      .rx_msg_valid, .rx_msg_fifo, .rx_msg_data);
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 40);
      if (n >= 40) begin
         n_fail++;
         report_and_stop();
      end
      r = s_axi_bresp;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 40);
      if (n >= 40) begin
         n_fail++;
         report_and_stop();
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      rd(ADDR_BIT_TIMING, d, r);
      chk(d, 32'h0000_2300);
      chk({28'h0, time_segment_one_q} + {28'h0, time_segment_two_q}, 32'h5);
      rd(8'h24, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(8'h30, 32'h1, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
   endtask
   task automatic t_fill;
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 1; i <= 4; i++) begin
         crf_can_node_i.send_frame(1'b0, 32'hc0 + i);
         rd(ADDR_FIFO0_CTRL, d, r);
         chk(d & 32'h3, (i > 3) ? 32'h3 : i);
      end
      rd(ADDR_FIFO1_CTRL, d, r);
      chk(d & 32'h3, 32'h0);
      rd(ADDR_IRQ_STATUS, d, r);
      chk(d, 32'h5);
      chk({31'h0, irq_q}, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h1, r);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq_q}, 32'h1);
      wr(ADDR_IRQ_STATUS, 32'h5, r);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq_q}, 32'h0);
      for (int i = 1; i <= 4; i++) begin
         rd(ADDR_FIFO0_DATA, d, r);
         if (i < 4) chk(d, 32'hc0 + i);
         wr(ADDR_FIFO0_CTRL, 32'h20, r);
         rd(ADDR_FIFO0_CTRL, d, r);
         chk(d & 32'h3, (i > 3) ? 32'h0 : 3 - i);
      end
   endtask
   // Sweeps the release across the store slot of a third message.
   task automatic t_coincide;
      logic [31:0] d;
      logic [1:0] r;
      for (int k = 86; k <= 98; k++) begin
         crf_can_node_i.send_frame(1'b1, 32'ha00 + k);
         crf_can_node_i.send_frame(1'b1, 32'hb00 + k);
         fork
            crf_can_node_i.send_frame(1'b1, 32'hd00 + k);
            begin
               repeat (k) @(posedge ref_clk);
               wr(ADDR_FIFO1_CTRL, 32'h20, r);
            end
         join
         rd(ADDR_FIFO1_CTRL, d, r);
         chk(d & 32'h3, 32'h2);
         rd(ADDR_FIFO1_DATA, d, r);
         chk(d, 32'hb00 + k);
         wr(ADDR_FIFO1_CTRL, 32'h20, r);
         rd(ADDR_FIFO1_DATA, d, r);
         chk(d, 32'hd00 + k);
         wr(ADDR_FIFO1_CTRL, 32'h20, r);
         rd(ADDR_IRQ_STATUS, d, r);
         chk(d & 32'h8, 32'h0);
      end
   endtask
   // Guarded release: test count, status and pin, then release with no gap.
   task automatic t_guarded;
      logic [31:0] c, s, g;
      logic [1:0] r;
      int n;
      crf_can_node_i.send_frame(1'b1, 32'he01);
      crf_can_node_i.send_frame(1'b1, 32'he02);
      fork
         crf_can_node_i.send_frame(1'b1, 32'he03);
         begin
            repeat (50) @(posedge ref_clk);
            n = 0;
            do begin
               rd(ADDR_FIFO1_CTRL, c, r);
               rd(ADDR_CELL_STATUS, s, r);
               rd(ADDR_DIAGNOSIS, g, r);
               n++;
            end while (c[1:0] == 2'h2 && s[STATUS_RX_BUSY_BIT]
               && g[DIAG_RX_PIN_BIT] && n < 40);
            if (n >= 40) begin
               n_fail++;
               report_and_stop();
            end
            wr(ADDR_FIFO1_CTRL, 32'h20, r);
         end
      join
      rd(ADDR_FIFO1_CTRL, c, r);
      chk(c & 32'h3, 32'h2);
      rd(ADDR_FIFO1_DATA, c, r);
      chk(c, 32'he02);
      wr(ADDR_FIFO1_CTRL, 32'h20, r);
      rd(ADDR_FIFO1_DATA, c, r);
      chk(c, 32'he03);
      wr(ADDR_FIFO1_CTRL, 32'h20, r);
   endtask
   task automatic t_status;
      logic [31:0] d;
      logic [1:0] r;
      rd(ADDR_DIAGNOSIS, d, r);
      chk(d & 32'h8, 32'h8);
      fork
         crf_can_node_i.send_frame(1'b0, 32'hf);
         begin
            repeat (36) @(posedge ref_clk);
            rd(ADDR_DIAGNOSIS, d, r);
            chk(d & 32'h8, 32'h0);
            rd(ADDR_CELL_STATUS, d, r);
            chk(d & 32'h20, 32'h20);
         end
      join
      rd(ADDR_CELL_STATUS, d, r);
      chk(d & 32'h20, 32'h0);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      sys_rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      t_regs();
      t_fill();
      t_coincide();
      t_guarded();
      t_status();
      report_and_stop();
   end
endmodule // can_rx_fifo_release_test

/* tb/crf_can_node.sv */
// Stand-in for the bus side: frame engine flags, receive pin and messages.
// Assumes eight clock cycles per bit, the reset bit timing of the block.
`timescale 1ns/10ps
module crf_can_node (
   input wire logic ref_clk,
   output logic can_rx_pin,
   output logic rx_frame_active,
   output logic rx_ack_seen,
   output logic rx_msg_valid,
   output logic rx_msg_fifo,
   output logic [crf_pkg::MSG_W-1:0] rx_msg_data
);
   import crf_pkg::*;
   localparam int BIT_CYC = 8;
   initial begin
      can_rx_pin = 1'b1;
      {rx_frame_active, rx_ack_seen, rx_msg_valid, rx_msg_fifo} = 4'h0;
      rx_msg_data = '1;
   end
   // Four payload bits, a dominant acknowledge, then a recessive tail of eight bits less four cycles.
   task automatic send_frame(input logic fifo, input logic [MSG_W-1:0] data);
      @(posedge ref_clk);
      rx_frame_active <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         can_rx_pin <= data[i];
         repeat (BIT_CYC) @(posedge ref_clk);
      end
      can_rx_pin <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rx_ack_seen <= 1'b1;
      rx_msg_valid <= 1'b1;
      rx_msg_fifo <= fifo;
      rx_msg_data <= data;
      @(posedge ref_clk);
      rx_ack_seen <= 1'b0;
      rx_msg_valid <= 1'b0;
      rx_msg_fifo <= ~fifo;
      rx_msg_data <= ~data;
      repeat (3) @(posedge ref_clk);
      can_rx_pin <= 1'b1;
      repeat (8 * BIT_CYC - 4) @(posedge ref_clk);
      rx_frame_active <= 1'b0;
      @(posedge ref_clk);
   endtask
endmodule // crf_can_node

/* tb/crf_top_props.sv */
// Port-level properties of the receive FIFO block.
// Assumes it is bound to crf_top and sees only that module's ports.
`timescale 1ns/10ps
module crf_top_props
   import crf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic [crf_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [crf_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic can_rx_pin,
   input wire logic rx_frame_active,
   input wire logic rx_ack_seen,
   input wire logic rx_msg_valid,
   input wire logic rx_store_q,
   input wire logic [crf_pkg::TIM_PRESC_W-1:0] baud_prescaler_q,
   input wire logic [crf_pkg::TIM_SEG_W-1:0] time_segment_one_q,
   input wire logic [crf_pkg::TIM_SEG_W-1:0] time_segment_two_q
);
   logic [11:0] since_ack_q;
   logic held_q, busy_q, pin_q, busy_rd_q, pin_rd_q;
   logic [ADDR_W-1:0] rd_addr_q;
   int guard;
   // From the acknowledge sample point the store slot lies seven whole bits later.
   assign guard = (ACK_TO_STORE_BITS + 1) * (1 + int'(baud_prescaler_q))
      * (3 + int'(time_segment_one_q) + int'(time_segment_two_q));
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         since_ack_q <= '0;
      end else if (rx_ack_seen) begin
         since_ack_q <= '0;
      end else if (since_ack_q != 12'hfff) begin
         since_ack_q <= since_ack_q + 12'h001;
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         held_q <= 1'b0;
      end else if (rx_msg_valid) begin
         held_q <= 1'b1;
      end else if (rx_store_q) begin
         held_q <= 1'b0;
      end
   end
   // Read data reflects the registered pin values at the edge that takes the address.
   always_ff @(posedge ref_clk) begin
      busy_q <= rx_frame_active;
      pin_q <= can_rx_pin;
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_q <= s_axi_araddr;
         busy_rd_q <= busy_q;
         pin_rd_q <= pin_q;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   store_pulse_a: assert property (rx_store_q |=> !rx_store_q)
      else $error("Store pulse lasted more than one cycle.");
   store_cause_a: assert property (rx_store_q |-> held_q)
      else $error("Store without a received message.");
   // The store pulse trails the store edge by one cycle.
   store_guard_a: assert property (rx_store_q |-> {20'h0, since_ack_q} > guard)
      else $error("Store came too soon after acknowledge.");
   status_read_a: assert property (
      $rose(s_axi_rvalid) && rd_addr_q == ADDR_CELL_STATUS
      |-> s_axi_rdata[STATUS_RX_BUSY_BIT] == busy_rd_q)
      else $error("Receive status read back wrong.");
   pin_read_a: assert property (
      $rose(s_axi_rvalid) && rd_addr_q == ADDR_DIAGNOSIS
      |-> s_axi_rdata[DIAG_RX_PIN_BIT] == pin_rd_q)
      else $error("Receive pin read back wrong.");
   unmapped_read_a: assert property ($rose(s_axi_rvalid) && rd_addr_q > ADDR_BIT_TIMING
      |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
      else $error("Unmapped read not refused.");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("Read answer late.");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
      else $error("Write answer late.");
endmodule // crf_top_props

bind crf_top crf_top_props crf_top_props_i (
   .ref_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .can_rx_pin,
   .rx_frame_active, .rx_ack_seen, .rx_msg_valid, .rx_store_q, .baud_prescaler_q,
   .time_segment_one_q, .time_segment_two_q
);
